// ==== trel_stage.sv ====
// trel_stage: start/trip/blocked timing, release handling, event and fault records
// assumes pick-up, block and the measured-to-pick-up ratio come from neighbouring logic
`timescale 1ns/1ns

// Behaviour
// - instant mode: trip rises in the same cycle as start
// - definite time: trip after the set delay while pick-up stays active
// - definite delay in 5 ms steps, default 40 ms, used only in DT
// - zero definite delay behaves exactly as instant
// - inverse time: t = k / (measured/pick-up ratio - 1)^a
// - delay-type selector, definite time after configuration reset
// - time dial k scales the inverse delay, used only in IDMT
// - exponent a is the power of the excess ratio, IDMT only
// - release delay in 5 ms steps, default 60 ms, start held meanwhile
// - delayed release on: start drops only after release delay
// - reset-after-release: counter clears after full release, else at drop
// - continue option keeps counter advancing through release, default off
// - no trip during release unless pick-up returns first
// - default: counter frozen while the release delay runs
// - events on rise and fall of start, trip, blocked, masked per type
// - each event carries timestamp and process voltages
// - circular history of the twelve latest fault records
// - fault record written only on rising start, trip or blocked
// - record: time, event, -20 ms, fault, -200 ms voltage, remaining, group
// - block active at pick-up gives blocked, no start, no timing
module trel_stage
  import trel_pkg::*;
#(
  parameter int P_TICK_CYC = TICK_CYC
)
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_pickup,
  input  wire logic              i_block,
  input  wire logic [V_W-1:0]    i_meas_volt,
  input  wire logic [15:0]       i_meas_ratio,
  input  wire logic [TS_W-1:0]   i_time_now,
  input  wire logic [2:0]        i_setting_group,
  input  wire logic              i_cfg_we,
  input  wire logic              i_cfg_idmt,
  input  wire logic [DT_W-1:0]   i_cfg_dt,
  input  wire logic [K_W-1:0]    i_cfg_k,
  input  wire logic [A_W-1:0]    i_cfg_a,
  input  wire logic [REL_W-1:0]  i_cfg_rel,
  input  wire logic              i_cfg_delayed_rel,
  input  wire logic              i_cfg_reset_after,
  input  wire logic              i_cfg_continue,
  input  wire logic [5:0]        i_evt_mask,
  input  wire logic [3:0]        i_rec_sel,
  output logic                   o_start,
  output logic                   o_trip,
  output logic                   o_blocked,
  output logic                   o_evt_valid,
  output logic [2:0]             o_evt_code,
  output logic [TS_W-1:0]        o_evt_time,
  output logic [V_W-1:0]         o_evt_volt,
  output logic [V_W-1:0]         o_evt_pre_volt,
  output trel_rec_t              o_rec,
  output logic [3:0]             o_rec_count
);

  typedef enum logic [2:0] {S_IDLE, S_RUN, S_REL, S_TRIP, S_BLK} trel_st_t;

  // ****************************************
  // configuration, reset to defaults
  // ****************************************
  logic              cfg_idmt_ff;
  logic [DT_W-1:0]   cfg_dt_ff;
  logic [K_W-1:0]    cfg_k_ff;
  logic [A_W-1:0]    cfg_a_ff;
  logic [REL_W-1:0]  cfg_rel_ff;
  logic              cfg_dly_ff;
  logic              cfg_rst_ff;
  logic              cfg_cont_ff;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg_idmt_ff <= 1'b0;
      cfg_dt_ff   <= DT_DEF;
      cfg_k_ff    <= K_DEF;
      cfg_a_ff    <= A_DEF;
      cfg_rel_ff  <= REL_DEF;
      cfg_dly_ff  <= 1'b1;
      cfg_rst_ff  <= 1'b1;
      cfg_cont_ff <= 1'b0;
    end
    else if (i_cfg_we)
    begin
      cfg_idmt_ff <= i_cfg_idmt;
      cfg_dt_ff   <= i_cfg_dt;
      cfg_k_ff    <= i_cfg_k;
      cfg_a_ff    <= i_cfg_a;
      cfg_rel_ff  <= i_cfg_rel;
      cfg_dly_ff  <= i_cfg_delayed_rel;
      cfg_rst_ff  <= i_cfg_reset_after;
      cfg_cont_ff <= i_cfg_continue;
    end
  end

  // ****************************************
  // program-cycle tick
  // ****************************************
  logic [15:0] tick_cnt_ff;
  logic        tick_ff;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tick_cnt_ff <= 16'h0000;
      tick_ff     <= 1'b0;
    end
    else
    begin
      tick_ff     <= (tick_cnt_ff == 16'(P_TICK_CYC - 1));
      tick_cnt_ff <= (tick_cnt_ff == 16'(P_TICK_CYC - 1)) ? 16'h0000 : tick_cnt_ff + 16'h0001;
    end
  end

  // ****************************************
  // inverse-time rate: (ratio-1)^a in q.8
  // ****************************************
  // integrating the rate per tick avoids a divider and follows a moving ratio
  logic [15:0]    xs;
  logic [39:0]    prod;
  logic [23:0]    prod_sat;
  logic [23:0]    pw_acc_ff;
  logic [23:0]    pow_ff;
  logic [A_W-1:0] pw_cnt_ff;

  assign xs       = (i_meas_ratio > RATIO_ONE) ? i_meas_ratio - RATIO_ONE : 16'h0001;
  assign prod     = pw_acc_ff * xs;
  assign prod_sat = (|prod[39:32]) ? 24'hffffff : prod[31:8];

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pw_acc_ff <= 24'h000000;
      pow_ff    <= 24'h000000;
      pw_cnt_ff <= '0;
    end
    else if (pw_cnt_ff == '0)
    begin
      pow_ff    <= pw_acc_ff;
      pw_acc_ff <= {8'h00, xs};
      pw_cnt_ff <= (cfg_a_ff > A_W'(1)) ? cfg_a_ff - A_W'(1) : '0;
    end
    else
    begin
      pw_acc_ff <= prod_sat;
      pw_cnt_ff <= pw_cnt_ff - A_W'(1);
    end
  end

  // ****************************************
  // operate/release state machine
  // ****************************************
  trel_st_t          st_ff;
  trel_st_t          nxt_st;
  logic [ACC_W-1:0]  acc_ff;
  logic [ACC_W-1:0]  nxt_acc;
  logic [REL_W-1:0]  rel_ff;
  logic [REL_W-1:0]  nxt_rel;
  logic              nxt_start;
  logic              nxt_trip;
  logic              nxt_blk;
  logic [ACC_W-1:0]  inc;
  logic [ACC_W-1:0]  target;
  logic [ACC_W-1:0]  acc_sum;
  logic              reached;
  logic              instant;

  assign inc     = cfg_idmt_ff ? {8'h00, pow_ff} : 32'h00000001;
  assign target  = cfg_idmt_ff ? ACC_W'(cfg_k_ff) << K_SHIFT : ACC_W'(cfg_dt_ff);
  assign acc_sum = acc_ff + inc;
  assign reached = acc_sum >= target;
  assign instant = !cfg_idmt_ff && (cfg_dt_ff == '0);

  always_comb
  begin
    nxt_st    = st_ff;
    nxt_acc   = acc_ff;
    nxt_rel   = rel_ff;
    nxt_start = o_start;
    nxt_trip  = o_trip;
    nxt_blk   = o_blocked;
    case (st_ff)
      S_IDLE:
        if (i_pickup)
        begin
          nxt_acc = '0;
          nxt_rel = '0;
          if (i_block)
          begin
            nxt_st  = S_BLK;
            nxt_blk = 1'b1;
          end
          else
          begin
            nxt_start = 1'b1;
            nxt_trip  = instant;
            nxt_st    = instant ? S_TRIP : S_RUN;
          end
        end
      S_RUN:
        if (i_block)
        begin
          nxt_st    = S_BLK;
          nxt_start = 1'b0;
          nxt_blk   = 1'b1;
          nxt_acc   = '0;
        end
        else if (!i_pickup)
        begin
          nxt_rel = '0;
          if (!cfg_rst_ff || cfg_rel_ff == '0)
            nxt_acc = '0;
          nxt_st    = (cfg_rel_ff == '0) ? S_IDLE : S_REL;
          nxt_start = cfg_dly_ff && (cfg_rel_ff != '0);
        end
        else if (tick_ff)
        begin
          nxt_acc  = reached ? target : acc_sum;
          nxt_trip = reached;
          nxt_st   = reached ? S_TRIP : S_RUN;
        end
      S_REL:
        if (i_pickup)
        begin
          nxt_st    = S_RUN;
          nxt_start = 1'b1;
        end
        else if (tick_ff)
        begin
          if (REL_W'(rel_ff + 1'b1) >= cfg_rel_ff)
          begin
            nxt_st    = S_IDLE;
            nxt_start = 1'b0;
            nxt_acc   = '0;
          end
          else
          begin
            nxt_rel = REL_W'(rel_ff + 1'b1);
            if (cfg_cont_ff)
              nxt_acc = reached ? target : acc_sum;
          end
        end
      S_TRIP:
        if (!i_pickup)
        begin
          nxt_st    = S_IDLE;
          nxt_start = 1'b0;
          nxt_trip  = 1'b0;
          nxt_acc   = '0;
        end
      S_BLK:
        if (!i_pickup || !i_block)
        begin
          nxt_st  = S_IDLE;
          nxt_blk = 1'b0;
        end
      default:
        nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff     <= S_IDLE;
      acc_ff    <= '0;
      rel_ff    <= '0;
      o_start   <= 1'b0;
      o_trip    <= 1'b0;
      o_blocked <= 1'b0;
    end
    else
    begin
      st_ff     <= nxt_st;
      acc_ff    <= nxt_acc;
      rel_ff    <= nxt_rel;
      o_start   <= nxt_start;
      o_trip    <= nxt_trip;
      o_blocked <= nxt_blk;
    end
  end

  // ****************************************
  // voltage history, one sample per tick
  // ****************************************
  logic [V_W-1:0] hist [HIST_N];
  logic [5:0]     hptr_ff;
  logic [5:0]     pre_idx;

  assign pre_idx = (hptr_ff >= 6'(PRE_TCK)) ? hptr_ff - 6'(PRE_TCK)
                                             : hptr_ff + 6'(HIST_N - PRE_TCK);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hptr_ff <= 6'h00;
      for (int i = 0; i < HIST_N; i++)
        hist[i] <= '0;
    end
    else if (tick_ff)
    begin
      hist[hptr_ff] <= i_meas_volt;
      hptr_ff <= (hptr_ff == 6'(HIST_N - 1)) ? 6'h00 : hptr_ff + 6'h01;
    end
  end

  // ****************************************
  // events and fault records
  // ****************************************
  logic [2:0]       q_ff;
  logic [2:0]       cur;
  logic [5:0]       edg;
  logic [5:0]       pend_ff;
  logic [5:0]       grant;
  logic [2:0]       gcode;
  logic [TS_W-1:0]  snap_t_ff;
  logic [V_W-1:0]   snap_v_ff;
  logic [V_W-1:0]   snap_pre_ff;
  logic [V_W-1:0]   prf_ff;
  logic [ACC_W-1:0] snap_rem_ff;
  trel_rec_t        rec [NREC];
  logic [3:0]       wptr_ff;

  assign cur   = {o_blocked, o_trip, o_start};
  assign edg   = {q_ff[2] & ~cur[2], cur[2] & ~q_ff[2], q_ff[1] & ~cur[1],
                  cur[1] & ~q_ff[1], q_ff[0] & ~cur[0], cur[0] & ~q_ff[0]};
  assign grant = pend_ff & (~pend_ff + 6'h01);

  always_comb
  begin
    gcode = 3'h0;
    for (int i = 5; i >= 0; i--)
      if (grant[i])
        gcode = 3'(i);
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q_ff        <= 3'h0;
      pend_ff     <= 6'h00;
      snap_t_ff   <= '0;
      snap_v_ff   <= '0;
      snap_pre_ff <= '0;
      snap_rem_ff <= '0;
      prf_ff      <= '0;
    end
    else
    begin
      q_ff    <= cur;
      pend_ff <= (pend_ff & ~grant) | edg;
      if (|edg)
      begin
        snap_t_ff   <= i_time_now;
        snap_v_ff   <= i_meas_volt;
        snap_pre_ff <= hist[pre_idx];
        snap_rem_ff <= target - acc_ff;
      end
      if ((nxt_start && !o_start) || (nxt_blk && !o_blocked))
        prf_ff <= hist[hptr_ff];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_evt_valid    <= 1'b0;
      o_evt_code     <= 3'h0;
      o_evt_time     <= '0;
      o_evt_volt     <= '0;
      o_evt_pre_volt <= '0;
      wptr_ff        <= 4'h0;
      o_rec_count    <= 4'h0;
      o_rec          <= '0;
      for (int i = 0; i < NREC; i++)
        rec[i] <= '0;
    end
    else
    begin
      o_evt_valid    <= |pend_ff && i_evt_mask[gcode];
      o_evt_code     <= gcode;
      o_evt_time     <= snap_t_ff;
      o_evt_volt     <= snap_v_ff;
      o_evt_pre_volt <= snap_pre_ff;
      if (|pend_ff && !gcode[0])
      begin
        rec[wptr_ff] <= '{snap_t_ff, gcode, snap_pre_ff, snap_v_ff, prf_ff,
                          snap_rem_ff, i_setting_group};
        wptr_ff      <= (wptr_ff == 4'(NREC - 1)) ? 4'h0 : wptr_ff + 4'h1;
        if (o_rec_count != 4'(NREC))
          o_rec_count <= o_rec_count + 4'h1;
      end
      o_rec <= (i_rec_sel < 4'(NREC)) ? rec[i_rec_sel] : '0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_INSTANT: assert property ($rose(o_start) && $past(instant) |-> o_trip)
    else $error("instant trip late");
  AST_DT_WAIT: assert property ($rose(o_trip) && !$past(cfg_idmt_ff) && !$past(instant)
    |-> $past(tick_ff) && $past(acc_ff) + 1 >= $past(cfg_dt_ff))
    else $error("definite trip early");
  AST_ZERO_DT: assert property (st_ff == S_IDLE && i_pickup && !i_block && instant
    |=> o_start && o_trip)
    else $error("zero delay not instant");
  AST_REL_HOLD: assert property (st_ff == S_RUN && !i_pickup && !i_block && cfg_dly_ff
    && cfg_rel_ff != '0 |=> o_start [*2])
    else $error("start not held");
  AST_CLR_DROP: assert property (st_ff == S_RUN && !i_pickup && !i_block && !cfg_rst_ff
    |=> acc_ff == '0)
    else $error("counter not cleared");
  AST_NO_REL_TRIP: assert property (st_ff == S_REL |=> !$rose(o_trip))
    else $error("trip in release");
  AST_FREEZE: assert property (st_ff == S_REL && $past(st_ff) == S_REL && !cfg_cont_ff
    && nxt_st == S_REL |=> acc_ff == $past(acc_ff))
    else $error("counter moved");
  AST_BLOCK: assert property (st_ff == S_IDLE && i_pickup && i_block
    |=> o_blocked && !o_start && !o_trip)
    else $error("block ignored");
  AST_TRIP_RST: assert property (st_ff == S_TRIP && !i_pickup
    |=> !o_trip && acc_ff == '0)
    else $error("trip held");
  AST_REC_ON: assert property (wptr_ff != $past(wptr_ff) |-> !$past(gcode[0])
    && $past(pend_ff) != 6'h00)
    else $error("record off edge");

  COV_TRIP: cover property ($rose(o_trip) && !instant);
  COV_REL:  cover property (st_ff == S_REL ##1 st_ff == S_RUN);
  COV_BLK:  cover property ($rose(o_blocked));
  COV_WRAP: cover property (o_rec_count == 4'(NREC) && $changed(wptr_ff));

endmodule // trel_stage

// ==== trel_pkg.sv ====
// trel_pkg: constants, defaults and record layout for the trip/release timing stage
// assumes a 10 MHz clock and a 5 ms program-cycle tick derived from it
package trel_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS   = 100;
  localparam int TICK_MS  = 5;
  localparam int TICK_CYC = (TICK_MS * 1000000) / CLK_NS;
  localparam int DT_DEF_MS  = 40;
  localparam int REL_DEF_MS = 60;
  localparam int PRE_MS     = 20;
  localparam int PRF_MS     = 200;
  localparam int PRE_TCK    = PRE_MS / TICK_MS;
  localparam int HIST_N     = PRF_MS / TICK_MS;

  // ****************************************
  // widths and defaults
  // ****************************************
  localparam int DT_W  = 19;
  localparam int K_W   = 13;
  localparam int A_W   = 5;
  localparam int REL_W = 15;
  localparam int V_W   = 16;
  localparam int ACC_W = 32;
  localparam int TS_W  = 32;
  localparam int K_SHIFT = 9;
  localparam int NREC  = 12;
  localparam logic [DT_W-1:0]  DT_DEF  = DT_W'(DT_DEF_MS / TICK_MS);
  localparam logic [REL_W-1:0] REL_DEF = REL_W'(REL_DEF_MS / TICK_MS);
  localparam logic [K_W-1:0]   K_DEF   = 13'h0005;
  localparam logic [A_W-1:0]   A_DEF   = 5'h01;
  localparam logic [15:0]      RATIO_ONE = 16'h0100;

  // event codes: bit 0 set marks the falling transition
  localparam logic [2:0] EV_START_ON  = 3'h0;
  localparam logic [2:0] EV_TRIP_ON   = 3'h2;
  localparam logic [2:0] EV_BLOCK_ON  = 3'h4;

  typedef struct packed {
    logic [TS_W-1:0]  tstamp;
    logic [2:0]       code;
    logic [V_W-1:0]   v_pre;
    logic [V_W-1:0]   v_flt;
    logic [V_W-1:0]   v_prf;
    logic [ACC_W-1:0] remain;
    logic [2:0]       sg;
  } trel_rec_t;

endpackage

// ==== trip_reset_timing_event_log_test.sv ====
// trip_reset_timing_event_log_test: self-checking bench for trel_stage
// assumes a shortened program-cycle tick of four clocks; inputs change at falling edges
`timescale 1ns/1ns

module trip_reset_timing_event_log_test;
  import trel_pkg::*;
  localparam int TK = 4;

  logic             i_clk = 1'b0;
  logic             i_rst_n = 1'b0;
  logic             i_pickup = 1'b0;
  logic             i_block = 1'b0;
  logic [15:0]      i_meas_ratio = 16'h0200;
  logic [V_W-1:0]   i_meas_volt = 16'h1111;
  logic [TS_W-1:0]  i_time_now = '0;
  logic             i_cfg_we = 1'b0;
  logic             i_cfg_idmt = 1'b0;
  logic [DT_W-1:0]  i_cfg_dt = DT_DEF;
  logic [K_W-1:0]   i_cfg_k = K_DEF;
  logic [A_W-1:0]   i_cfg_a = A_DEF;
  logic [REL_W-1:0] i_cfg_rel = REL_DEF;
  logic             i_cfg_delayed_rel = 1'b1;
  logic             i_cfg_reset_after = 1'b1;
  logic             i_cfg_continue = 1'b0;
  logic [5:0]       i_evt_mask = 6'h3f;
  logic [3:0]       i_rec_sel = 4'h0;
  logic             o_start;
  logic             o_trip;
  logic             o_blocked;
  logic             o_evt_valid;
  logic [2:0]       o_evt_code;
  logic [TS_W-1:0]  o_evt_time;
  logic [V_W-1:0]   o_evt_volt;
  logic [V_W-1:0]   o_evt_pre_volt;
  trel_rec_t        o_rec;
  logic [3:0]       o_rec_count;
  int               n_fail = 0;
  int               comparisons = 0;
  int               cycles = 0;

  trel_stage #(.P_TICK_CYC(TK)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_pickup(i_pickup), .i_block(i_block),
    .i_meas_volt(i_meas_volt), .i_meas_ratio(i_meas_ratio), .i_time_now(i_time_now),
    .i_setting_group(3'h5), .i_cfg_we(i_cfg_we), .i_cfg_idmt(i_cfg_idmt),
    .i_cfg_dt(i_cfg_dt), .i_cfg_k(i_cfg_k), .i_cfg_a(i_cfg_a), .i_cfg_rel(i_cfg_rel),
    .i_cfg_delayed_rel(i_cfg_delayed_rel), .i_cfg_reset_after(i_cfg_reset_after),
    .i_cfg_continue(i_cfg_continue), .i_evt_mask(i_evt_mask), .i_rec_sel(i_rec_sel),
    .o_start(o_start), .o_trip(o_trip), .o_blocked(o_blocked), .o_evt_valid(o_evt_valid),
    .o_evt_code(o_evt_code), .o_evt_time(o_evt_time), .o_evt_volt(o_evt_volt),
    .o_evt_pre_volt(o_evt_pre_volt), .o_rec(o_rec), .o_rec_count(o_rec_count)
  );

  initial
  begin
    forever #50 i_clk = ~i_clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  // timestamp just follows the cycle count
  always @(negedge i_clk)
  begin
    cycles++;
    i_time_now <= TS_W'(cycles);
    if (cycles > 20000)
    begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic cfg(logic idmt, int dt, int rel, logic del, logic ra, logic cont);
    i_cfg_idmt = idmt;
    i_cfg_dt = DT_W'(dt);
    i_cfg_rel = REL_W'(rel);
    i_cfg_delayed_rel = del;
    i_cfg_reset_after = ra;
    i_cfg_continue = cont;
    i_cfg_we = 1'b1;
    cyc(1);
    i_cfg_we = 1'b0;
    cyc(1);
  endtask

  // raise pick-up, count clocks until trip, optionally drop and settle
  task automatic run_trip(output int n, input logic drop);
    i_pickup = 1'b1;
    n = 0;
    while (o_trip !== 1'b1 && n < 3000)
    begin
      cyc(1);
      n++;
    end
    if (drop)
    begin
      i_pickup = 1'b0;
      cyc(4);
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_instant();
    int n;
    logic [2:0] seen[$];
    cfg(1'b0, 0, 12, 1'b1, 1'b1, 1'b0);
    i_pickup = 1'b1;
    for (n = 0; n < 8; n++)
    begin
      cyc(1);
      if (o_start === 1'b1 && seen.size() == 0) chk("trip with start", 1, o_trip);
      if (o_evt_valid === 1'b1) seen.push_back(o_evt_code);
      if (o_start === 1'b1 && seen.size() == 0) seen.push_back(3'h7);
    end
    i_pickup = 1'b0;
    cyc(2);
    chk("trip cleared", 0, o_trip);
    for (n = 0; n < 6; n++)
    begin
      cyc(1);
      if (o_evt_valid === 1'b1) seen.push_back(o_evt_code);
    end
    chk("event count", 5, seen.size());
    chk("ev start on", EV_START_ON, seen[1]);
    chk("ev trip on", EV_TRIP_ON, seen[2]);
    chk("ev start off", 1, seen[3]);
    chk("ev trip off", 3, seen[4]);
    $display("test instant done");
  endtask

  task automatic t_definite();
    int n;
    cfg(1'b0, 8, 12, 1'b1, 1'b1, 1'b0);
    run_trip(n, 1'b1);
    chk("dt window", 1, (n >= 7 * TK + 1) && (n <= 8 * (TK + 1) + 2));
    // start record of this run sits in slot 3 after fifteen earlier writes
    i_rec_sel = 4'h3;
    cyc(2);
    chk("rec start code", EV_START_ON, o_rec.code);
    chk("rec remaining", 8, o_rec.remain);
    // idmt settings must not disturb definite time
    i_cfg_k = 13'h0001;
    cfg(1'b0, 8, 12, 1'b1, 1'b1, 1'b0);
    run_trip(n, 1'b1);
    chk("dt ignores k", 1, n >= 7 * TK + 1);
    $display("test definite done");
  endtask

  task automatic t_release();
    int n;
    cfg(1'b0, 8, 12, 1'b1, 1'b1, 1'b0);
    i_pickup = 1'b1;
    cyc(2 * TK);
    i_pickup = 1'b0;
    cyc(3);
    chk("start held", 1, o_start);
    n = 0;
    while (o_start === 1'b1 && n < 200)
    begin
      chk("no trip in release", 0, o_trip);
      cyc(1);
      n++;
    end
    chk("release window", 1, (n >= 10 * TK) && (n <= 12 * (TK + 1) + 3));
    run_trip(n, 1'b1);
    chk("cleared after release", 1, n >= 7 * TK + 1);
    // frozen counter resumes where it stopped
    i_pickup = 1'b1;
    cyc(4 * TK);
    i_pickup = 1'b0;
    cyc(2 * TK);
    run_trip(n, 1'b1);
    chk("frozen resume", 1, n <= 5 * (TK + 1) + 2);
    // counter runs on during release when asked
    cfg(1'b0, 8, 12, 1'b1, 1'b1, 1'b1);
    i_pickup = 1'b1;
    cyc(4 * TK);
    i_pickup = 1'b0;
    for (n = 0; n < 6 * TK; n++)
    begin
      cyc(1);
      chk("no trip while released", 0, o_trip);
    end
    run_trip(n, 1'b1);
    chk("continue resume", 1, n <= TK + 3);
    // no reset-after: counter clears at drop
    cfg(1'b0, 8, 12, 1'b1, 1'b0, 1'b0);
    i_pickup = 1'b1;
    cyc(4 * TK);
    i_pickup = 1'b0;
    cyc(TK);
    run_trip(n, 1'b1);
    chk("clear at drop", 1, n >= 7 * TK);
    // undelayed release drops start at once
    cfg(1'b0, 8, 12, 1'b0, 1'b1, 1'b0);
    i_pickup = 1'b1;
    cyc(TK);
    i_pickup = 1'b0;
    cyc(3);
    chk("start quick drop", 0, o_start);
    cyc(16 * TK);
    $display("test release done");
  endtask

  task automatic t_idmt();
    int n1;
    int n2;
    i_cfg_k = 13'h0008;
    i_cfg_a = 5'h01;
    i_meas_ratio = 16'h0300;
    cfg(1'b1, 400, 0, 1'b1, 1'b1, 1'b0);
    run_trip(n1, 1'b1);
    chk("idmt a1 window", 1, (n1 >= 7 * TK) && (n1 <= 8 * (TK + 1) + 3));
    i_cfg_a = 5'h02;
    cfg(1'b1, 400, 0, 1'b1, 1'b1, 1'b0);
    run_trip(n2, 1'b1);
    chk("idmt a2 window", 1, (n2 >= 3 * TK) && (n2 <= 4 * (TK + 1) + 3));
    $display("test idmt done");
  endtask

  task automatic t_block_records();
    int n;
    logic [TS_W-1:0] ts;
    cfg(1'b0, 0, 0, 1'b1, 1'b1, 1'b0);
    // old level fills the history, a newer one sits in the last ten ticks
    i_meas_volt = 16'h1111;
    cyc(HIST_N * TK);
    i_meas_volt = 16'h2222;
    cyc(10 * TK);
    i_meas_volt = 16'h1234;
    i_block = 1'b1;
    i_pickup = 1'b1;
    #1 ts = i_time_now + 1;
    cyc(3);
    chk("block event", 1, o_evt_valid);
    chk("event code", EV_BLOCK_ON, o_evt_code);
    chk("event time", ts, o_evt_time);
    chk("event volt", 16'h1234, o_evt_volt);
    chk("event pre volt", 16'h2222, o_evt_pre_volt);
    cyc(1);
    chk("blocked", 1, o_blocked);
    chk("no start", 0, o_start);
    chk("one record", 1, o_rec_count);
    i_rec_sel = 4'h0;
    cyc(2);
    chk("rec code", EV_BLOCK_ON, o_rec.code);
    chk("rec volt", 16'h1234, o_rec.v_flt);
    chk("rec group", 3'h5, o_rec.sg);
    chk("rec pre volt", 16'h2222, o_rec.v_pre);
    chk("rec prefault volt", 16'h1111, o_rec.v_prf);
    chk("rec time", ts, o_rec.tstamp);
    i_pickup = 1'b0;
    i_block = 1'b0;
    cyc(4);
    chk("no rec on fall", 1, o_rec_count);
    i_evt_mask = 6'h00;
    i_pickup = 1'b1;
    for (n = 0; n < 6; n++)
    begin
      cyc(1);
      chk("masked event", 0, o_evt_valid);
    end
    i_pickup = 1'b0;
    cyc(4);
    i_evt_mask = 6'h3f;
    repeat (5) run_trip(n, 1'b1);
    chk("records saturate", NREC, o_rec_count);
    $display("test records done");
  endtask

  // reset in mid-run must bring back the default definite delay
  task automatic t_defaults();
    int n;
    i_rst_n = 1'b0;
    cyc(2);
    i_rst_n = 1'b1;
    cyc(2);
    chk("start after mid reset", 0, o_start);
    chk("count after mid reset", 0, o_rec_count);
    run_trip(n, 1'b1);
    chk("default dt window", 1, (n >= 7 * TK + 1) && (n <= 8 * (TK + 1) + 2));
    $display("test defaults done");
  endtask

  initial
  begin
    cyc(2);
    i_rst_n = 1'b1;
    cyc(2);
    chk("start after reset", 0, o_start);
    chk("count after reset", 0, o_rec_count);
    t_block_records();
    t_instant();
    t_definite();
    t_release();
    t_idmt();
    t_defaults();
    end_sim();
  end

endmodule // trip_reset_timing_event_log_test
